// *** logic/psrs_pkg.sv ***
//
// Contract
// - input status byte: global, read-only, resets zero
// - bit7 input OV fault, bit6 OV warning
// - bit5 input UV warning, bit4 UV fault
// - temperature status byte per page, resets zero
// - bit7 over-temperature fault, bit6 its warning
// - bit5 under-temperature warning, bit4 its fault
// - comm/logic error byte: global, read-only, zero
// - bit7 on invalid or unsupported command
// - bit6 on invalid or unsupported data
// - bit5 on packet error
// - bit1 on write to read-only, other faults
// - vendor monitor byte: global, read-only, zero
// - bit6 on single-wire link error
// - bit5 when aux voltage 10% below UV
// - bit4 when aux voltage 10% above OV
// - bit3 on external clock sync loss
// - bit1 when aux voltage below UV limit
// - bit0 when aux voltage above OV limit
// - input voltage reading, global, two-byte Linear-11
// - summary "other" bit on any status bit
// - summary temperature bit on any temperature bit
//
package psrs_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] PSRS_CMD_INPUT = 8'h7C;
    localparam logic [7:0] PSRS_CMD_TEMP  = 8'h7D;
    localparam logic [7:0] PSRS_CMD_CML   = 8'h7E;
    localparam logic [7:0] PSRS_CMD_MFR   = 8'h80;
    localparam logic [7:0] PSRS_CMD_VIN   = 8'h88;

    // ------------------------------------------------------------
    // bit positions and reset values
    // ------------------------------------------------------------
    localparam int PSRS_B_HI_FAULT   = 7;   // ov / overtemperature_fault
    localparam int PSRS_B_HI_WARN    = 6;   // ov / overtemperature_warning
    localparam int PSRS_B_LO_WARN    = 5;   // uv / undertemperature_warning
    localparam int PSRS_B_LO_FAULT   = 4;   // uv / undertemperature_fault
    localparam int PSRS_B_CML_CMD    = 7;
    localparam int PSRS_B_CML_DATA   = 6;
    localparam int PSRS_B_CML_PEC    = 5;
    localparam int PSRS_B_CML_OTHER  = 1;
    localparam int PSRS_B_MFR_LINK   = 6;
    localparam int PSRS_B_MFR_UVWARN = 5;
    localparam int PSRS_B_MFR_OVWARN = 4;
    localparam int PSRS_B_MFR_SYNC   = 3;
    localparam int PSRS_B_MFR_UVFLT  = 1;
    localparam int PSRS_B_MFR_OVFLT  = 0;
    localparam int PSRS_B_SUM_OTHER  = 9;   // summary word
    localparam int PSRS_B_SUM_TEMP   = 2;   // summary byte
    localparam int PSRS_EXP_LSB      = 11;  // linear-11 exponent
    localparam logic [7:0]  PSRS_RST_BYTE = 8'h00;
    localparam logic [15:0] PSRS_RST_WORD = 16'h0000;
    // implemented-bit masks: all other bits stay zero
    localparam logic [7:0]  PSRS_MASK_INT = 8'hF0;
    localparam logic [7:0]  PSRS_MASK_CML = 8'hE2;
    localparam logic [7:0]  PSRS_MASK_MFR = 8'h7B;
    localparam int          PSRS_PAGES    = 2;
    localparam logic [1:0]  PSRS_LEN_ONE  = 2'h1;
    localparam logic [1:0]  PSRS_LEN_TWO  = 2'h2;
    localparam logic [4:0]  PSRS_WARN_NUM_LO = 5'h09;  // 90 % of uv limit
    localparam logic [4:0]  PSRS_WARN_NUM_HI = 5'h0B;  // 110 % of ov limit
    localparam logic [4:0]  PSRS_WARN_DEN    = 5'h0A;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic hi_fault;
        logic hi_warn;
        logic lo_warn;
        logic lo_fault;
    } psrs_lim_evt_t;

    typedef struct packed {
        logic bad_cmd;
        logic bad_data;
        logic pec_err;
        logic other;
    } psrs_comm_evt_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic        page;
    } psrs_cmd_t;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic        err;
        logic [1:0]  len;
        logic [15:0] data;
    } psrs_rsp_t;

endpackage : psrs_pkg

// *** logic/psrs_status.sv ***
module psrs_status
    import psrs_pkg::*;
(
    input  wire logic           clk,           // device clock, 125 MHz
    input  wire logic           rst_n,         // synchronous reset, low
    input  wire psrs_cmd_t      cmd,           // command from bus engine
    output psrs_rsp_t           rsp_q,         // answer, one cycle later
    input  wire logic           clr_faults,    // clear-all-faults pulse
    input  wire psrs_lim_evt_t  vin_evt,       // input voltage events
    input  wire psrs_lim_evt_t  temp_evt [PSRS_PAGES], // per-page temp events
    input  wire psrs_comm_evt_t comm_evt,      // bus engine error events
    input  wire logic           link_err,      // single-wire link error
    input  wire logic           sync_lost,     // external clock sync lost
    input  wire logic [15:0]    aux_volt,      // aux monitor reading
    input  wire logic [15:0]    aux_uv_lim,    // aux undervoltage limit
    input  wire logic [15:0]    aux_ov_lim,    // aux overvoltage limit
    input  wire logic           vin_strobe,    // new input voltage sample
    input  wire logic [4:0]     vin_exp,       // signed exponent
    input  wire logic [10:0]    vin_mant,      // signed mantissa
    input  wire logic           other_any,     // other status bytes nonzero
    output logic                sum_other_q,   // summary word bit 9
    output logic [PSRS_PAGES-1:0] sum_temp_q   // summary byte bit 2, per page
);

    // ------------------------------------------------------------
    // event mapping
    // ------------------------------------------------------------
    // all event inputs come from logic on this clock, so no synchronisers
    wire logic [7:0] in_set;
    wire logic [7:0] tp_set [PSRS_PAGES];
    wire logic [7:0] cml_set;
    wire logic [7:0] mfr_set;
    wire logic       is_ours;
    wire logic       wr_ro;

    assign in_set = {vin_evt, 4'h0};

    assign is_ours = (cmd.code == PSRS_CMD_INPUT) || (cmd.code == PSRS_CMD_TEMP)
                  || (cmd.code == PSRS_CMD_CML) || (cmd.code == PSRS_CMD_MFR)
                  || (cmd.code == PSRS_CMD_VIN);
    // a write to any of these read-only commands is a comm fault
    assign wr_ro = cmd.valid && cmd.write && is_ours;

    assign cml_set = {comm_evt.bad_cmd,
                      comm_evt.bad_data,
                      comm_evt.pec_err,
                      3'h0,
                      comm_evt.other || wr_ro,
                      1'b0};

    // ------------------------------------------------------------
    // aux monitor comparisons
    // ------------------------------------------------------------
    // warnings compare aux*10 against lim*9 or lim*11: exact, no divider
    wire logic [20:0] aux_x10;
    wire logic [20:0] uv_x9;
    wire logic [20:0] ov_x11;
    wire logic        aux_uv_flt;
    wire logic        aux_ov_flt;
    wire logic        aux_uv_wrn;
    wire logic        aux_ov_wrn;

    assign aux_x10    = 21'(aux_volt) * 21'(PSRS_WARN_DEN);
    assign uv_x9      = 21'(aux_uv_lim) * 21'(PSRS_WARN_NUM_LO);
    assign ov_x11     = 21'(aux_ov_lim) * 21'(PSRS_WARN_NUM_HI);
    assign aux_uv_flt = aux_volt < aux_uv_lim;
    assign aux_ov_flt = aux_volt > aux_ov_lim;
    assign aux_uv_wrn = aux_x10 < uv_x9;
    assign aux_ov_wrn = aux_x10 > ov_x11;

    assign mfr_set = {1'b0, link_err,
                      aux_uv_wrn, aux_ov_wrn,
                      sync_lost,
                      1'b0, aux_uv_flt, aux_ov_flt};

    // ------------------------------------------------------------
    // status bytes
    // ------------------------------------------------------------
    wire logic [7:0] in_q;
    wire logic [7:0] tp_q [PSRS_PAGES];
    wire logic [7:0] cml_q;
    wire logic [7:0] mfr_q;

    // global input byte
    psrs_sticky #(.MASK(PSRS_MASK_INT)) u_input (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (in_set),
        .clr   (clr_faults),
        .q     (in_q)
    );

    // one temperature byte per page
    genvar p;
    generate
        for (p = 0; p < PSRS_PAGES; p++)
        begin : g_page
            assign tp_set[p] = {temp_evt[p], 4'h0};
            psrs_sticky #(.MASK(PSRS_MASK_INT)) u_temp (
                .clk   (clk),
                .rst_n (rst_n),
                .set   (tp_set[p]),
                .clr   (clr_faults),
                .q     (tp_q[p])
            );
        end
    endgenerate

    // global comm/logic byte
    psrs_sticky #(.MASK(PSRS_MASK_CML)) u_cml (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (cml_set),
        .clr   (clr_faults),
        .q     (cml_q)
    );

    // global vendor monitor byte
    psrs_sticky #(.MASK(PSRS_MASK_MFR)) u_mfr (
        .clk   (clk),
        .rst_n (rst_n),
        .set   (mfr_set),
        .clr   (clr_faults),
        .q     (mfr_q)
    );

    // ------------------------------------------------------------
    // input voltage reading
    // ------------------------------------------------------------
    logic [15:0] vin_q;
    logic [15:0] vin_d;

    // exponent on top, mantissa below; held between samples
    assign vin_d = vin_strobe ? {vin_exp, vin_mant} : vin_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            vin_q <= PSRS_RST_WORD;
        else
            vin_q <= vin_d;
    end

    // ------------------------------------------------------------
    // read answer
    // ------------------------------------------------------------
    // page is only meaningful for the temperature byte; the rest are global
    wire logic [7:0]  tp_sel;
    wire psrs_rsp_t   rsp_d;
    wire logic        rd;

    assign tp_sel = tp_q[cmd.page];
    assign rd     = cmd.valid && !cmd.write;

    assign rsp_d.valid = cmd.valid;
    assign rsp_d.hit   = is_ours;
    assign rsp_d.err   = cmd.valid && (cmd.write || !is_ours);
    assign rsp_d.len   = !rd || !is_ours ? 2'h0
                       : (cmd.code == PSRS_CMD_VIN) ? PSRS_LEN_TWO : PSRS_LEN_ONE;
    assign rsp_d.data  = !rd                        ? PSRS_RST_WORD
                       : (cmd.code == PSRS_CMD_INPUT) ? {8'h00, in_q}
                       : (cmd.code == PSRS_CMD_TEMP)  ? {8'h00, tp_sel}
                       : (cmd.code == PSRS_CMD_CML)   ? {8'h00, cml_q}
                       : (cmd.code == PSRS_CMD_MFR)   ? {8'h00, mfr_q}
                       : (cmd.code == PSRS_CMD_VIN)   ? vin_q
                       : PSRS_RST_WORD;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rsp_q <= '0;
        else
            rsp_q <= rsp_d;
    end

    // ------------------------------------------------------------
    // summary bits
    // ------------------------------------------------------------
    wire logic                  any_tp;
    wire logic [PSRS_PAGES-1:0] tp_any;

    generate
        for (p = 0; p < PSRS_PAGES; p++)
        begin : g_sum
            assign tp_any[p] = |tp_q[p];
        end
    endgenerate
    assign any_tp = |tp_any;

    // summary bits lag the status bytes by one clock
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sum_other_q <= 1'b0;
            sum_temp_q  <= '0;
        end
        else
        begin
            sum_other_q <= (|in_q) || any_tp || (|cml_q) || (|mfr_q) || other_any;
            sum_temp_q  <= tp_any;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_vin_read;
        cmd.valid && !cmd.write && (cmd.code == PSRS_CMD_VIN);
    endsequence

    sequence s_vin_answer;
        rsp_q.valid && (rsp_q.len == PSRS_LEN_TWO) && (rsp_q.data == $past(vin_q));
    endsequence

    a_input_overvoltage_fault: assert property (vin_evt.hi_fault |=> in_q[PSRS_B_HI_FAULT])
        else $error("input ov fault not latched");

    a_vin_uv_warn: assert property (vin_evt.lo_warn |=> in_q[PSRS_B_LO_WARN])
        else $error("input uv warning not latched");

    a_temp_ot: assert property (temp_evt[0].hi_warn |=> tp_q[0][PSRS_B_HI_WARN])
        else $error("over-temperature warning not latched");

    a_temp_ut: assert property (temp_evt[1].lo_fault |=> tp_q[1][PSRS_B_LO_FAULT])
        else $error("under-temperature fault not latched");

    a_cml_bad_cmd: assert property (comm_evt.bad_cmd |=> cml_q[PSRS_B_CML_CMD])
        else $error("bad command not flagged");

    a_cml_data_pec: assert property ((comm_evt.bad_data && comm_evt.pec_err)
                    |=> cml_q[PSRS_B_CML_DATA] && cml_q[PSRS_B_CML_PEC])
        else $error("data or packet error not flagged");

    a_cml_ro_write: assert property (wr_ro |=> cml_q[PSRS_B_CML_OTHER] && rsp_q.err)
        else $error("write to read-only not flagged");

    a_aux_uv_fault: assert property (aux_uv_flt |=> mfr_q[PSRS_B_MFR_UVFLT])
        else $error("aux undervoltage fault not latched");

    a_aux_warn_fault: assert property (aux_uv_wrn |-> aux_uv_flt)
        else $error("aux uv warning without fault");

    a_unused_zero: assert property (((in_q & ~PSRS_MASK_INT) == 8'h00)
                    && ((cml_q & ~PSRS_MASK_CML) == 8'h00)
                    && ((mfr_q & ~PSRS_MASK_MFR) == 8'h00))
        else $error("unused status bit set");

    a_vin_read: assert property (s_vin_read |=> s_vin_answer)
        else $error("input voltage read answer wrong");

    a_sum_other: assert property (($changed(in_q) && (|in_q)) |=> sum_other_q)
        else $error("summary other bit missing");

    sequence s_byte_read;
        cmd.valid && !cmd.write && is_ours && (cmd.code != PSRS_CMD_VIN);
    endsequence

    sequence s_byte_answer;
        rsp_q.valid && !rsp_q.err && (rsp_q.len == PSRS_LEN_ONE) && (rsp_q.data[15:8] == 8'h00);
    endsequence

    a_input_undervoltage_fault: assert property (vin_evt.lo_fault |=> in_q[PSRS_B_LO_FAULT])
        else $error("input uv fault not latched");

    a_temp_overtemperature_fault: assert property (temp_evt[1].hi_fault |=> tp_q[1][PSRS_B_HI_FAULT])
        else $error("over-temperature fault not latched");

    a_mfr_link: assert property (link_err |=> mfr_q[PSRS_B_MFR_LINK])
        else $error("link error not latched");

    a_aux_uv_warn: assert property (aux_uv_wrn |=> mfr_q[PSRS_B_MFR_UVWARN])
        else $error("aux undervoltage warning not latched");

    a_aux_ov_warn: assert property (aux_ov_wrn |=> mfr_q[PSRS_B_MFR_OVWARN])
        else $error("aux overvoltage warning not latched");

    a_mfr_sync: assert property (sync_lost |=> mfr_q[PSRS_B_MFR_SYNC])
        else $error("sync loss not latched");

    a_aux_ov_fault: assert property (aux_ov_flt |=> mfr_q[PSRS_B_MFR_OVFLT])
        else $error("aux overvoltage fault not latched");

    a_page_sum: assert property (tp_any[0] |=> sum_temp_q[0])
        else $error("summary temperature bit missing");

    a_sum_other_any: assert property (other_any |=> sum_other_q)
        else $error("summary other bit missing for other bytes");

    a_byte_read: assert property (s_byte_read |=> s_byte_answer)
        else $error("status byte read answer wrong");

    a_temp_read: assert property ((cmd.valid && !cmd.write && (cmd.code == PSRS_CMD_TEMP))
        |=> (rsp_q.data[7:0] == ($past(cmd.page) ? $past(tp_q[1]) : $past(tp_q[0]))))
        else $error("temperature byte read from wrong page");

    a_write_refused: assert property ((cmd.valid && cmd.write)
        |=> rsp_q.err && (rsp_q.len == 2'h0) && (rsp_q.data == PSRS_RST_WORD))
        else $error("write to read-only answered");

    a_vin_fields: assert property (vin_strobe
        |=> (vin_q[15:PSRS_EXP_LSB] == $past(vin_exp))
            && (vin_q[PSRS_EXP_LSB-1:0] == $past(vin_mant)))
        else $error("input voltage fields misplaced");

endmodule : psrs_status

// *** logic/psrs_sticky.sv ***
// sticky flag byte: set wins over clear, unmapped bits held at zero
module psrs_sticky
    import psrs_pkg::*;
#(
    parameter logic [7:0] MASK = 8'hFF  // implemented bits
)(
    input  wire logic       clk,    // device clock
    input  wire logic       rst_n,  // synchronous reset, low
    input  wire logic [7:0] set,    // event pulses or levels
    input  wire logic       clr,    // clear-all pulse
    output logic      [7:0] q       // sticky status
);

    // ------------------------------------------------------------
    // one flag per bit
    // ------------------------------------------------------------
    wire logic [7:0] q_d;  // next flag values

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_bit
            // set beats clear so an event in the clearing cycle survives;
            // an unmapped bit can never set, so it reads zero
            assign q_d[i] = MASK[i] && (set[i] || (q[i] && !clr));
        end
    endgenerate

    // one register for the whole byte keeps every bit on a single driver
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            q <= PSRS_RST_BYTE;
        else
            q <= q_d;
    end

endmodule : psrs_sticky

// *** testbench/psrs_host.sv ***
// bus-engine side: one command per call, answer taken a cycle later
module psrs_host
    import psrs_pkg::*;
(
    input  wire logic      clk,   // device clock
    input  wire psrs_rsp_t rsp_q, // answer from the block
    output psrs_cmd_t      cmd    // command toward the block
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cmd = '0;

    // ----------------------------------------
    // command cycle
    // ----------------------------------------
    // released fields flip, so a stale code never looks like a live one
    task automatic xfer(input logic [7:0] code, input logic wr, input logic pg,
                        output psrs_rsp_t r);
        @(negedge clk);
        cmd = '{valid: 1'b1, write: wr, code: code, page: pg};
        @(negedge clk);
        r = rsp_q;
        cmd = '{valid: 1'b0, write: ~wr, code: ~code, page: ~pg};
    endtask : xfer
endmodule : psrs_host

// *** testbench/tb_psrs_status.sv ***
module tb_psrs_status
    import psrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    psrs_cmd_t             cmd;
    psrs_rsp_t             rsp_q;
    logic                  clr_faults = 1'b0;
    psrs_lim_evt_t         vin_evt = '0;
    psrs_lim_evt_t         temp_evt [PSRS_PAGES] = '{default: '0};
    psrs_comm_evt_t        comm_evt = '0;
    logic                  link_err = 1'b0;
    logic                  sync_lost = 1'b0;
    logic [15:0]           aux_volt = 16'h03E8;
    logic [15:0]           aux_uv_lim = 16'h03E8;
    logic [15:0]           aux_ov_lim = 16'h07D0;
    logic                  vin_strobe = 1'b0;
    logic [4:0]            vin_exp = 5'h00;
    logic [10:0]           vin_mant = 11'h000;
    logic                  other_any = 1'b0;
    logic                  sum_other_q;
    logic [PSRS_PAGES-1:0] sum_temp_q;
    psrs_rsp_t             r;
    logic [15:0]           w;
    int                    errors = 0;
    int                    tests_run = 0;
    int                    cycles = 0;
    logic [7:0]            cml_exp [4] = '{8'h80, 8'h40, 8'h20, 8'h02};
    logic [7:0]            codes [5] = '{8'h7C, 8'h7D, 8'h7E, 8'h80, 8'h88};
    int                    aux_pts [8] = '{1000, 999, 900, 899, 2000, 2001, 2200, 2201};

    psrs_status psrs_status_inst (.clk(clk), .rst_n(rst_n), .cmd(cmd), .rsp_q(rsp_q),
        .clr_faults(clr_faults), .vin_evt(vin_evt), .temp_evt(temp_evt),
        .comm_evt(comm_evt), .link_err(link_err), .sync_lost(sync_lost),
        .aux_volt(aux_volt), .aux_uv_lim(aux_uv_lim), .aux_ov_lim(aux_ov_lim),
        .vin_strobe(vin_strobe), .vin_exp(vin_exp), .vin_mant(vin_mant),
        .other_any(other_any), .sum_other_q(sum_other_q), .sum_temp_q(sum_temp_q));

    psrs_host psrs_host_inst (.clk(clk), .rsp_q(rsp_q), .cmd(cmd));

    // ----------------------------------------
    // clock and hang guard
    // ----------------------------------------
    always #4 clk = ~clk;

    // whole run is under two thousand cycles, so this only trips on a hang
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            end_sim();
        end
    end

    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    task automatic cmp_rsp(input psrs_rsp_t got, input psrs_rsp_t exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected answer at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp_rsp

    task automatic cmp_flag(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected summary at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp_flag

    task automatic rd(input logic [7:0] c, input logic pg, input logic [15:0] d,
                      input logic [1:0] ln);
        psrs_rsp_t a;
        psrs_host_inst.xfer(c, 1'b0, pg, a);
        cmp_rsp(a, '{valid: 1'b1, hit: 1'b1, err: 1'b0, len: ln, data: d});
    endtask : rd

    // extra cycle lets the summary bits settle back to zero
    task automatic clear();
        @(negedge clk);
        clr_faults = 1'b1;
        @(negedge clk);
        clr_faults = 1'b0;
        @(negedge clk);
    endtask : clear

    function automatic logic [7:0] exp_aux(int a, int u, int o);
        exp_aux = {2'b00, a * 10 < u * 9, a * 10 > o * 11, 2'b00, a < u, a > o};
    endfunction : exp_aux

    // limits and a neutral level change together, then one sample of a
    task automatic aux_case(input int u, input int o, input int a);
        @(negedge clk);
        aux_uv_lim = 16'(u);
        aux_ov_lim = 16'(o);
        aux_volt = 16'(u);
        clear();
        aux_volt = 16'(a);
        @(negedge clk);
        aux_volt = 16'(u);
        rd(PSRS_CMD_MFR, 1'b0, {8'h00, exp_aux(a, u, o)}, PSRS_LEN_ONE);
    endtask : aux_case

    task automatic check_zero();
        rd(PSRS_CMD_INPUT, 1'b0, 16'h0000, PSRS_LEN_ONE);
        rd(PSRS_CMD_TEMP, 1'b0, 16'h0000, PSRS_LEN_ONE);
        rd(PSRS_CMD_TEMP, 1'b1, 16'h0000, PSRS_LEN_ONE);
        rd(PSRS_CMD_CML, 1'b0, 16'h0000, PSRS_LEN_ONE);
        rd(PSRS_CMD_MFR, 1'b0, 16'h0000, PSRS_LEN_ONE);
        rd(PSRS_CMD_VIN, 1'b0, 16'h0000, PSRS_LEN_TWO);
        cmp_flag({sum_other_q, sum_temp_q}, 3'h0);
    endtask : check_zero

    task automatic end_sim();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'hBC04B6CD));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        check_zero();
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk);
            vin_evt = psrs_lim_evt_t'(4'h8 >> i);
            @(negedge clk);
            vin_evt = '0;
            rd(PSRS_CMD_INPUT, 1'b0, 16'(8'h80 >> i), PSRS_LEN_ONE);
            cmp_flag({sum_other_q, sum_temp_q}, 3'h4);
            clear();
        end
        for (int p = 0; p < PSRS_PAGES; p++)
            for (int i = 0; i < 4; i++)
            begin
                @(negedge clk);
                temp_evt[p] = psrs_lim_evt_t'(4'h8 >> i);
                @(negedge clk);
                temp_evt[p] = '0;
                rd(PSRS_CMD_TEMP, 1'(p), 16'(8'h80 >> i), PSRS_LEN_ONE);
                rd(PSRS_CMD_TEMP, ~1'(p), 16'h0000, PSRS_LEN_ONE);
                cmp_flag({sum_other_q, sum_temp_q}, {1'b1, 2'(1 << p)});
                clear();
            end
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk);
            comm_evt = psrs_comm_evt_t'(4'h8 >> i);
            @(negedge clk);
            comm_evt = '0;
            rd(PSRS_CMD_CML, 1'b0, {8'h00, cml_exp[i]}, PSRS_LEN_ONE);
            clear();
        end
        @(negedge clk);
        link_err = 1'b1;
        @(negedge clk);
        link_err = 1'b0;
        sync_lost = 1'b1;
        @(negedge clk);
        sync_lost = 1'b0;
        rd(PSRS_CMD_MFR, 1'b0, 16'h0048, PSRS_LEN_ONE);
        foreach (aux_pts[i])
            aux_case(1000, 2000, aux_pts[i]);
        repeat (16)
        begin
            w = 16'($urandom_range(2000, 100));
            aux_case(int'(w), int'(w) + $urandom_range(2000, 0), $urandom_range(4500, 0));
        end
        aux_case(1000, 2000, 1000);
        // writes are refused and flagged, unknown codes only refused
        for (int i = 0; i < 5; i++)
        begin
            psrs_host_inst.xfer(codes[i], 1'b1, 1'b0, r);
            cmp_rsp(r, '{valid: 1'b1, hit: 1'b1, err: 1'b1, len: 2'h0, data: 16'h0});
            rd(PSRS_CMD_CML, 1'b0, 16'h0002, PSRS_LEN_ONE);
            clear();
        end
        psrs_host_inst.xfer(8'h7F, 1'b0, 1'b0, r);
        cmp_rsp(r, '{valid: 1'b1, hit: 1'b0, err: 1'b1, len: 2'h0, data: 16'h0});
        rd(PSRS_CMD_CML, 1'b0, 16'h0000, PSRS_LEN_ONE);
        @(negedge clk);
        vin_evt = psrs_lim_evt_t'(4'h8);
        clr_faults = 1'b1;
        @(negedge clk);
        vin_evt = '0;
        clr_faults = 1'b0;
        rd(PSRS_CMD_INPUT, 1'b0, 16'h0080, PSRS_LEN_ONE);
        clear();
        @(negedge clk);
        other_any = 1'b1;
        repeat (3) @(negedge clk);
        cmp_flag({sum_other_q, sum_temp_q}, 3'h4);
        other_any = 1'b0;
        repeat (3) @(negedge clk);
        cmp_flag({sum_other_q, sum_temp_q}, 3'h0);
        // the reading must hold its sample once the strobe drops
        repeat (20)
        begin
            w = 16'($urandom);
            @(negedge clk);
            {vin_exp, vin_mant} = w;
            vin_strobe = 1'b1;
            @(negedge clk);
            vin_strobe = 1'b0;
            {vin_exp, vin_mant} = ~w;
            rd(PSRS_CMD_VIN, 1'b0, w, PSRS_LEN_TWO);
        end
        @(negedge clk);
        vin_evt = '1;
        temp_evt = '{default: '1};
        comm_evt = '1;
        link_err = 1'b1;
        sync_lost = 1'b1;
        aux_uv_lim = 16'h07D0;
        aux_ov_lim = 16'h03E8;
        aux_volt = 16'h05DC;
        @(negedge clk);
        vin_evt = '0;
        temp_evt = '{default: '0};
        comm_evt = '0;
        link_err = 1'b0;
        sync_lost = 1'b0;
        aux_uv_lim = 16'h03E8;
        aux_ov_lim = 16'h07D0;
        aux_volt = 16'h03E8;
        rd(PSRS_CMD_INPUT, 1'b0, 16'h00F0, PSRS_LEN_ONE);
        rd(PSRS_CMD_TEMP, 1'b0, 16'h00F0, PSRS_LEN_ONE);
        rd(PSRS_CMD_TEMP, 1'b1, 16'h00F0, PSRS_LEN_ONE);
        rd(PSRS_CMD_CML, 1'b0, 16'h00E2, PSRS_LEN_ONE);
        rd(PSRS_CMD_MFR, 1'b0, 16'h007B, PSRS_LEN_ONE);
        cmp_flag({sum_other_q, sum_temp_q}, 3'h7);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        check_zero();
        end_sim();
    end
endmodule : tb_psrs_status
